// ===== rtl/snf_pkg.sv
// package: feature register map, field positions, defaults and opcodes
package snf_pkg;
  localparam logic [7:0] SNF_OP_GET_FEATURE  = 8'h0f;
  localparam logic [7:0] SNF_OP_SET_FEATURE  = 8'h1f;
  localparam logic [7:0] SNF_OP_SOFT_RESET   = 8'hff;
  localparam logic [7:0] SNF_ADDR_SECTOR0    = 8'h80;
  localparam logic [7:0] SNF_ADDR_SECTOR1    = 8'h84;
  localparam logic [7:0] SNF_ADDR_SECTOR2    = 8'h88;
  localparam logic [7:0] SNF_ADDR_SECTOR3    = 8'h8c;
  localparam logic [7:0] SNF_ADDR_PROTECTION = 8'ha0;
  localparam logic [7:0] SNF_ADDR_CONFIG     = 8'hb0;
  localparam logic [7:0] SNF_ADDR_STATE      = 8'hc0;
  // protection register fields
  localparam int SNF_PR_LOCK_MODE = 7;
  localparam int SNF_PR_BP_LSB    = 3;
  localparam int SNF_PR_TB        = 2;
  localparam int SNF_PR_LOCKDOWN  = 0;
  // configuration register fields
  localparam int SNF_CR_OTP_LOCK  = 7;
  localparam int SNF_CR_OTP_EN    = 6;
  localparam int SNF_CR_ECC_EN    = 4;
  localparam int SNF_CR_DRV_LSB   = 1;
  localparam int SNF_CR_QE        = 0;
  // state register fields
  localparam int SNF_SR_ECC_LSB   = 4;
  localparam int SNF_SR_PFAIL     = 3;
  localparam int SNF_SR_EFAIL     = 2;
  localparam int SNF_SR_WEL       = 1;
  localparam int SNF_SR_BUSY      = 0;
  // writable masks and power-up values
  localparam logic [7:0] SNF_PR_WMASK     = 8'hfd;
  localparam logic [7:0] SNF_CR_WMASK     = 8'h57;
  localparam logic [7:0] SNF_PR_RESET     = 8'h7c;
  localparam logic [7:0] SNF_CR_RESET     = 8'h10;
  localparam logic [3:0] SNF_BP_ALL_MASK  = 4'hc;
  localparam int         SNF_PAGE_BITS    = 17;
  localparam int         SNF_BLOCK_SHIFT  = 6;
  localparam logic [16:0] SNF_PAGE_LAST   = 17'h1ffff;
  // soft reset busy time in ns, and in 10 ns clk cycles
  localparam int         SNF_RESET_NS     = 500;
  localparam int         SNF_RESET_CYC    = (SNF_RESET_NS + 9) / 10;
endpackage : snf_pkg

// ===== rtl/snf_feature_regs.sv
// module: feature register bank, spi command decoder and array protect decode
`timescale 1ns/1ps
// Functional notes
// - get/set feature opcodes plus address byte
// - four sector ecc registers, read only
// - a0h protection, b0h config, c0h state
// - sector registers return index and result
// - soft reset keeps protection and config
// - soft reset sets busy until done
// - power-up protection and config defaults
// - power-up ecc from page0 block0, flags zero
// - soft reset clears state and sector fields
// - reserved bits writes have no effect
// - block protect and top/bottom are read/write
// - mode and lockdown select protection scheme
// - lockdown freezes protection until power cycle
// - quad enable: writable, pin is data
// - mode bit with pin low locks
// - power cycle returns mode/lockdown to zero
// - code zero none, code 11xx all
// - top/bottom 0 protects uppermost blocks
// - top/bottom 1 protects lowest blocks
// - protected program or erase is ignored
// - protected program/erase sets fail bits
module snf_feature_regs
  import snf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_di,
  output logic             spi_do,
  output logic             spi_do_oe_n,
  input  wire logic        write_protect_n,
  input  wire logic        otp_locked,
  input  wire logic [3:0]  boot_sector_ecc [4],
  input  wire logic [1:0]  boot_ecc_summary,
  input  wire logic        op_start,
  input  wire logic        op_is_erase,
  input  wire logic [16:0] op_page,
  input  wire logic        op_otp_locked,
  output logic             op_accept,
  output logic             op_reject,
  input  wire logic        ecc_valid,
  input  wire logic [3:0]  ecc_sector [4],
  input  wire logic [1:0]  ecc_summary,
  input  wire logic        wel_set,
  input  wire logic        wel_clr,
  input  wire logic        busy_in,
  output logic [7:0]       protection_reg,
  output logic [7:0]       configuration_reg,
  output logic [7:0]       state_reg,
  output logic             quad_enable_bit
);

  typedef enum logic [1:0] {SNF_IDLE, SNF_ADDR, SNF_WDATA, SNF_RDATA} snf_phase_t;

  typedef struct packed {
    logic [1:0]  sclk_sync;
    logic [1:0]  cs_sync;
    logic [1:0]  di_sync;
    logic [1:0]  wp_sync;
    logic        sclk_prev;
    snf_phase_t  phase;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  opcode;
    logic [7:0]  addr;
    logic [7:0]  rdata;
    logic        dout;
    logic        drive;
    logic [7:0]  prot;
    logic [7:0]  cfg;
    logic [1:0]  ecc_sum;
    logic        pfail;
    logic        efail;
    logic        write_enable_latch;
    logic        boot;
    logic [15:0] sec;
    logic [9:0]  rst_cnt;
    logic        accept;
    logic        reject;
  } snf_state_t;

  snf_state_t st;
  snf_state_t next_st;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_active;
  logic        prot_writable;
  logic        region_hit;
  logic [3:0]  bp;
  logic [16:0] span;
  logic [7:0]  rd_mux;
  logic [7:0]  byte_in;

  assign sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
  assign sclk_fall = ~st.sclk_sync[1] & st.sclk_prev;
  assign cs_active = ~st.cs_sync[1];
  assign byte_in   = {st.shreg[6:0], st.di_sync[1]};
  assign bp        = st.prot[SNF_PR_BP_LSB +: 4];

  // protection lock decision
  always_comb begin
    if (st.prot[SNF_PR_LOCKDOWN])
      prot_writable = 1'b0;
    else if (st.cfg[SNF_CR_QE])
      prot_writable = 1'b1;
    else
      prot_writable = ~st.prot[SNF_PR_LOCK_MODE] | st.wp_sync[1];
  end

  // protected span: 2^(n-1) blocks of 64 pages, all for 11xx
  always_comb begin
    span = '0;
    if (bp != 4'h0)
      span = 17'((64 << (bp - 4'h1)) - 1);
    if ((bp & SNF_BP_ALL_MASK) == SNF_BP_ALL_MASK)
      region_hit = 1'b1;
    else if (bp == 4'h0)
      region_hit = 1'b0;
    else if (st.prot[SNF_PR_TB])
      region_hit = op_page <= span;
    else
      region_hit = op_page >= (SNF_PAGE_LAST - span);
  end

  // read mux; reserved bits read as zero
  always_comb begin
    unique case (st.addr)
      SNF_ADDR_SECTOR0:    rd_mux = {4'h0, st.sec[3:0]};
      SNF_ADDR_SECTOR1:    rd_mux = {4'h1, st.sec[7:4]};
      SNF_ADDR_SECTOR2:    rd_mux = {4'h2, st.sec[11:8]};
      SNF_ADDR_SECTOR3:    rd_mux = {4'h3, st.sec[15:12]};
      SNF_ADDR_PROTECTION: rd_mux = st.prot;
      SNF_ADDR_CONFIG:     rd_mux = st.cfg;
      SNF_ADDR_STATE:      rd_mux = state_reg;
      default:             rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.sclk_sync = {st.sclk_sync[0], spi_clk};
    next_st.cs_sync   = {st.cs_sync[0], spi_cs_n};
    next_st.di_sync   = {st.di_sync[0], spi_di};
    next_st.wp_sync   = {st.wp_sync[0], write_protect_n};
    next_st.sclk_prev = st.sclk_sync[1];
    next_st.accept    = 1'b0;
    next_st.reject    = 1'b0;
    // capture otp lock and boot ecc one cycle after release
    if (st.boot) begin
      next_st.boot    = 1'b0;
      next_st.cfg[SNF_CR_OTP_LOCK] = otp_locked;
      next_st.ecc_sum = boot_ecc_summary;
      for (int i = 0; i < 4; i++)
        next_st.sec[i*4 +: 4] = boot_sector_ecc[i];
    end
    if (ecc_valid) begin
      next_st.ecc_sum = ecc_summary;
      for (int i = 0; i < 4; i++)
        next_st.sec[i*4 +: 4] = ecc_sector[i];
    end
    if (wel_clr)
      next_st.write_enable_latch = 1'b0;
    if (wel_set)
      next_st.write_enable_latch = 1'b1;
    if (op_start) begin
      next_st.pfail = 1'b0;
      next_st.efail = 1'b0;
      if (region_hit || (!op_is_erase && op_otp_locked)) begin
        next_st.reject = 1'b1;
        if (op_is_erase)
          next_st.efail = 1'b1;
        else
          next_st.pfail = 1'b1;
      end else begin
        next_st.accept = 1'b1;
      end
    end
    if (st.rst_cnt != '0)
      next_st.rst_cnt = st.rst_cnt - 10'd1;
    // serial command engine
    if (!cs_active) begin
      next_st.phase  = SNF_IDLE;
      next_st.bitcnt = '0;
      next_st.drive  = 1'b0;
    end else if (sclk_rise && st.phase != SNF_RDATA) begin
      next_st.shreg  = byte_in;
      next_st.bitcnt = st.bitcnt + 3'd1;
      if (st.bitcnt == 3'd7) begin
        unique case (st.phase)
          SNF_IDLE: begin
            next_st.opcode = byte_in;
            if (byte_in == SNF_OP_GET_FEATURE || byte_in == SNF_OP_SET_FEATURE)
              next_st.phase = SNF_ADDR;
            else if (byte_in == SNF_OP_SOFT_RESET) begin
              next_st.rst_cnt = 10'(SNF_RESET_CYC);
              next_st.ecc_sum = 2'b00;
              next_st.pfail   = 1'b0;
              next_st.efail   = 1'b0;
              next_st.write_enable_latch     = 1'b0;
              next_st.sec     = '0;
              // configuration, otp access included, is left alone
            end
          end
          SNF_ADDR: begin
            next_st.addr = byte_in;
            if (st.opcode == SNF_OP_GET_FEATURE)
              next_st.phase = SNF_RDATA;
            else
              next_st.phase = SNF_WDATA;
          end
          SNF_WDATA: begin
            next_st.phase = SNF_IDLE;
            if (st.addr == SNF_ADDR_PROTECTION && prot_writable)
              next_st.prot = (byte_in & SNF_PR_WMASK) | (st.prot & ~SNF_PR_WMASK);
            else if (st.addr == SNF_ADDR_CONFIG)
              next_st.cfg = (byte_in & SNF_CR_WMASK) | (st.cfg & ~SNF_CR_WMASK);
            // state and sector registers keep their contents
          end
          default: next_st.phase = SNF_IDLE;
        endcase
      end
    end
    if (cs_active && st.phase == SNF_RDATA && sclk_fall) begin
      if (!st.drive) begin
        next_st.drive  = 1'b1;
        next_st.rdata  = {rd_mux[6:0], 1'b0};
        next_st.dout   = rd_mux[7];
      end else begin
        next_st.dout   = st.rdata[7];
        next_st.rdata  = {st.rdata[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st         <= '0;
      st.prot    <= SNF_PR_RESET;
      st.cfg     <= SNF_CR_RESET;
      st.boot    <= 1'b1;
      st.cs_sync <= 2'b11;
      st.phase   <= SNF_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign spi_do            = st.dout;
  assign spi_do_oe_n       = ~st.drive;
  assign op_accept         = st.accept;
  assign op_reject         = st.reject;
  assign protection_reg    = st.prot;
  assign configuration_reg = st.cfg;
  assign quad_enable_bit   = st.cfg[SNF_CR_QE];
  assign state_reg = {2'b00, st.ecc_sum, st.pfail, st.efail, st.write_enable_latch,
                      busy_in | (st.rst_cnt != '0)};

  a_lockdown_holds: assert property (@(posedge clk) disable iff (!resetn)
    st.prot[SNF_PR_LOCKDOWN] |=> $stable(st.prot))
    else $error("protection changed under lockdown");
  a_reset_busy: assert property (@(posedge clk) disable iff (!resetn)
    ($rose(st.rst_cnt != '0)) |-> state_reg[SNF_SR_BUSY])
    else $error("busy not set on soft reset");
  a_busy_ends: assert property (@(posedge clk) disable iff (!resetn)
    (st.rst_cnt == 10'd1 && !busy_in) |=> !state_reg[SNF_SR_BUSY] || busy_in)
    else $error("busy did not clear");
  a_reject_fail: assert property (@(posedge clk) disable iff (!resetn)
    st.reject |-> (st.pfail ^ st.efail))
    else $error("reject without fail bit");
  a_all_protect: assert property (@(posedge clk) disable iff (!resetn)
    ((bp & SNF_BP_ALL_MASK) == SNF_BP_ALL_MASK) |-> region_hit)
    else $error("all-array code not protecting");
  a_none_protect: assert property (@(posedge clk) disable iff (!resetn)
    (bp == 4'h0) |-> !region_hit)
    else $error("code zero protects");
  a_pin_locks: assert property (@(posedge clk) disable iff (!resetn)
    (!st.cfg[SNF_CR_QE] && st.prot[SNF_PR_LOCK_MODE] && !st.wp_sync[1]) |-> !prot_writable)
    else $error("pin low did not lock");
  a_reset_keeps: assert property (@(posedge clk) disable iff (!resetn)
    $rose(st.rst_cnt != '0) |-> $stable(st.prot) && st.sec == '0 && !st.write_enable_latch)
    else $error("soft reset effects wrong");
  a_quad_free: assert property (@(posedge clk) disable iff (!resetn)
    (st.cfg[SNF_CR_QE] && !st.prot[SNF_PR_LOCKDOWN]) |-> prot_writable)
    else $error("quad mode blocks protection write");

  // a soft reset opcode has just been taken
  sequence s_soft_reset_taken;
    $rose(st.rst_cnt != '0);
  endsequence

  // a program or erase request lands in the protected span
  sequence s_op_refused;
    op_start && region_hit;
  endsequence

  a_cfg_keeps: assert property (@(posedge clk) disable iff (!resetn)
    s_soft_reset_taken |-> $stable(st.cfg) && st.ecc_sum == 2'b00 && !st.pfail && !st.efail)
    else $error("soft reset disturbed config or kept flags");
  a_lock_write: assert property (@(posedge clk) disable iff (!resetn)
    !prot_writable |=> $stable(st.prot))
    else $error("locked protection register changed");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    (protection_reg & ~SNF_PR_WMASK) == 8'h00 && !configuration_reg[SNF_CR_ECC_EN + 1]
      && !configuration_reg[SNF_CR_DRV_LSB + 2])
    else $error("reserved bit set");

  // block-granular decode, checked on the page's block index
  a_one_top: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && bp == 4'h1 && !st.prot[SNF_PR_TB])
      |-> region_hit == (&op_page[SNF_PAGE_BITS-1:SNF_BLOCK_SHIFT]))
    else $error("single top block decode wrong");
  a_one_bottom: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && bp == 4'h1 && st.prot[SNF_PR_TB])
      |-> region_hit == (~|op_page[SNF_PAGE_BITS-1:SNF_BLOCK_SHIFT]))
    else $error("single bottom block decode wrong");
  a_half_top: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && bp == 4'hb && !st.prot[SNF_PR_TB]) |-> region_hit == op_page[SNF_PAGE_BITS-1])
    else $error("upper half decode wrong");
  a_half_bottom: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && bp == 4'hb && st.prot[SNF_PR_TB]) |-> region_hit == !op_page[SNF_PAGE_BITS-1])
    else $error("lower half decode wrong");

  a_boot_capture: assert property (@(posedge clk) disable iff (!resetn)
    ($fell(st.boot) && !$past(ecc_valid)) |-> st.ecc_sum == $past(boot_ecc_summary)
      && st.cfg[SNF_CR_OTP_LOCK] == $past(otp_locked))
    else $error("boot ecc or otp lock not captured");
  a_oe_idle: assert property (@(posedge clk) disable iff (!resetn)
    !cs_active |=> spi_do_oe_n)
    else $error("data pin driven while deselected");
  a_sector_index: assert property (@(posedge clk) disable iff (!resetn)
    (st.addr[7:4] == SNF_ADDR_SECTOR0[7:4] && st.addr[1:0] == 2'b00)
      |-> rd_mux[7:4] == {2'b00, st.addr[3:2]})
    else $error("sector index field wrong");
  a_accept_clean: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && !region_hit && !op_otp_locked) |=> op_accept && !op_reject)
    else $error("unprotected operation refused");
  a_otp_program: assert property (@(posedge clk) disable iff (!resetn)
    (op_start && !op_is_erase && op_otp_locked) |=> op_reject && state_reg[SNF_SR_PFAIL])
    else $error("locked otp program not refused");
  a_op_refused: assert property (@(posedge clk) disable iff (!resetn)
    s_op_refused |=> op_reject && !op_accept)
    else $error("protected operation accepted");

endmodule : snf_feature_regs

// ===== testbench/snf_host_model.sv
// host-side spi controller model that issues feature commands
`timescale 1ns/1ps
module snf_host_model (
  input  wire logic clk,
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_di,
  input  wire logic spi_do
);
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_di = 1'b0;
  end
  // one byte msb first: data set after the fall, read data taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_di = tx[i];
      #62.5 spi_clk = 1'b1;
      rx[i] = spi_do;
      #62.5 spi_clk = 1'b0;
    end
  endtask : xfer
  // opcode, then address, then one data byte; n gives how many bytes are sent
  task automatic frame(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] wd,
                       input int n, output logic [7:0] rd);
    logic [7:0] junk;
    // start off both clk edges so no pin moves at a sampling edge
    @(negedge clk);
    #1.25;
    spi_cs_n = 1'b0;
    #62.5;
    xfer(op, junk);
    if (n > 1) xfer(adr, junk);
    if (n > 2) xfer(wd, rd);
    #62.5 spi_cs_n = 1'b1;
    // released data line must not keep showing the last bit
    spi_di = ~spi_di;
    #250;
  endtask : frame
endmodule : snf_host_model

// ===== testbench/tb_top.sv
// self-checking bench for the feature register bank
`timescale 1ns/1ps
module tb_top
  import snf_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wp_n = 1'b1;
  logic        otp_locked = 1'b1;
  logic        op_start = 1'b0;
  logic        op_otp = 1'b0;
  logic        op_erase = 1'b0;
  logic [16:0] op_page = 17'h0;
  logic        ecc_valid = 1'b0;
  logic        wel_set = 1'b0;
  logic [1:0]  boot_sum = 2'b01;
  logic [1:0]  ecc_sum = 2'b11;
  logic [3:0]  boot_ecc [4] = '{4'h3, 4'h1, 4'h2, 4'h0};
  logic [3:0]  ecc_sec [4] = '{4'h5, 4'h6, 4'h7, 4'h8};
  logic        spi_clk, spi_cs_n, spi_di, spi_do, oe_n, acc, rej, qe;
  logic [7:0]  prot, cfg, st, v;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;
  // protection value, erase, reject expected, page
  logic [26:0] tab [12] = '{{8'h00, 2'b00, 17'h1ffff}, {8'h04, 2'b10, 17'h00000},
    {8'h08, 2'b01, 17'h1ffc0}, {8'h08, 2'b10, 17'h1ffbf}, {8'h58, 2'b11, 17'h10000},
    {8'h58, 2'b00, 17'h0ffff}, {8'h0c, 2'b01, 17'h0003f}, {8'h0c, 2'b10, 17'h00040},
    {8'h5c, 2'b11, 17'h0ffff}, {8'h5c, 2'b00, 17'h10000}, {8'h60, 2'b01, 17'h00000},
    {8'h78, 2'b11, 17'h1ffff}};

  always #5 clk = ~clk;

  snf_host_model host (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
    .spi_do(spi_do));

  snf_feature_regs dut (
    .clk(clk), .resetn(resetn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
    .spi_do(spi_do), .spi_do_oe_n(oe_n), .write_protect_n(wp_n), .otp_locked(otp_locked),
    .boot_sector_ecc(boot_ecc), .boot_ecc_summary(boot_sum), .op_start(op_start),
    .op_is_erase(op_erase), .op_page(op_page), .op_otp_locked(op_otp), .op_accept(acc),
    .op_reject(rej), .ecc_valid(ecc_valid), .ecc_sector(ecc_sec), .ecc_summary(ecc_sum),
    .wel_set(wel_set), .wel_clr(1'b0), .busy_in(1'b0), .protection_reg(prot),
    .configuration_reg(cfg), .state_reg(st), .quad_enable_bit(qe));

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    host.frame(SNF_OP_GET_FEATURE, adr, 8'h00, 3, d);
    chk($sformatf("reg %h", adr), exp, d);
  endtask : rd

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] junk;
    host.frame(SNF_OP_SET_FEATURE, adr, d, 3, junk);
  endtask : wr

  task automatic op(input logic er, input logic [16:0] pg, input logic rj);
    @(negedge clk);
    op_erase = er;
    op_page = pg;
    op_start = 1'b1;
    @(negedge clk);
    op_start = 1'b0;
    chk("op_reject", {7'h0, rj}, {7'h0, rej});
    chk("op_accept", {7'h0, ~rj}, {7'h0, acc});
    if (rj) chk("fail bit", 8'h01, {7'h0, st[er ? SNF_SR_EFAIL : SNF_SR_PFAIL]});
  endtask : op

  task automatic power_cycle;
    @(negedge clk);
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
  endtask : power_cycle

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    power_cycle();
    rd(SNF_ADDR_PROTECTION, 8'h7c);
    chk("oe_n", 8'h01, {7'h0, oe_n});
    rd(SNF_ADDR_CONFIG, 8'h90);
    rd(SNF_ADDR_STATE, {2'b00, boot_sum, 4'h0});
    for (int i = 0; i < 4; i++) begin
      rd(SNF_ADDR_SECTOR0 + 8'(4 * i), {2'b00, 2'(i), boot_ecc[i]});
    end
    wr(SNF_ADDR_PROTECTION, 8'h02);
    rd(SNF_ADDR_PROTECTION, 8'h00);
    wr(SNF_ADDR_CONFIG, 8'h3e);
    rd(SNF_ADDR_CONFIG, 8'h96);
    wr(SNF_ADDR_CONFIG, 8'h10);
    wr(SNF_ADDR_STATE, 8'hff);
    wr(SNF_ADDR_SECTOR3, 8'hff);
    rd(SNF_ADDR_STATE, {2'b00, boot_sum, 4'h0});
    rd(SNF_ADDR_SECTOR3, {4'h3, boot_ecc[3]});
    // mode bit with the pin low, then quad enable overriding the pin
    wr(SNF_ADDR_PROTECTION, 8'h80);
    @(negedge clk);
    wp_n = 1'b0;
    wr(SNF_ADDR_PROTECTION, 8'h00);
    rd(SNF_ADDR_PROTECTION, 8'h80);
    wr(SNF_ADDR_CONFIG, 8'h11);
    chk("qe", 8'h01, {7'h0, qe});
    chk("cfg", 8'h91, cfg);
    wr(SNF_ADDR_PROTECTION, 8'h88);
    rd(SNF_ADDR_PROTECTION, 8'h88);
    wr(SNF_ADDR_CONFIG, 8'h10);
    wr(SNF_ADDR_PROTECTION, 8'h00);
    rd(SNF_ADDR_PROTECTION, 8'h88);
    @(negedge clk);
    wp_n = 1'b1;
    wr(SNF_ADDR_PROTECTION, 8'h00);
    rd(SNF_ADDR_PROTECTION, 8'h00);
    foreach (tab[i]) begin
      wr(SNF_ADDR_PROTECTION, tab[i][26:19]);
      chk("prot", tab[i][26:19], prot);
      op(tab[i][18], tab[i][16:0], tab[i][17]);
    end
    // locked otp area refuses a program but not an erase
    wr(SNF_ADDR_PROTECTION, 8'h00);
    @(negedge clk);
    op_otp = 1'b1;
    op(1'b0, 17'h00000, 1'b1);
    op(1'b1, 17'h00000, 1'b0);
    op_otp = 1'b0;
    // soft reset after loading fresh ecc results and the write latch
    wr(SNF_ADDR_PROTECTION, 8'h28);
    @(negedge clk);
    ecc_valid = 1'b1;
    wel_set = 1'b1;
    @(negedge clk);
    ecc_valid = 1'b0;
    wel_set = 1'b0;
    rd(SNF_ADDR_SECTOR1, 8'h16);
    host.frame(SNF_OP_SOFT_RESET, 8'h00, 8'h00, 1, v);
    chk("busy", 8'h01, {7'h0, st[SNF_SR_BUSY]});
    for (int k = 0; k < 200 && st[SNF_SR_BUSY] !== 1'b0; k++) @(negedge clk);
    chk("state", 8'h00, st);
    rd(SNF_ADDR_SECTOR2, 8'h20);
    rd(SNF_ADDR_PROTECTION, 8'h28);
    rd(SNF_ADDR_CONFIG, 8'h90);
    // lockdown holds against every write until power is cycled
    wr(SNF_ADDR_PROTECTION, 8'h01);
    wr(SNF_ADDR_PROTECTION, 8'h00);
    rd(SNF_ADDR_PROTECTION, 8'h01);
    power_cycle();
    rd(SNF_ADDR_PROTECTION, 8'h7c);
    wrap_up();
  end
endmodule : tb_top
